// ### dv/program_sequencer_stack_tb.sv
module program_sequencer_stack_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0]  op;
        logic [13:0] arg;
        logic [1:0]  len;
        logic [13:0] ip;
        logic [2:0]  lvl;
    } pss_row_t;

    logic        CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, CMD_VALID = 1'b0, CARRY_IN = 1'b0;
    logic [3:0]  CMD_OP = 4'h0, ACC_IN = 4'h0, TEMP_IN = 4'h0, REG_ADDR = 4'h0;
    logic [13:0] CMD_ARG = 14'h0000, ROM_ADDR, IP, first_addr;
    logic [1:0]  CMD_LEN = 2'h1, RAM_GROUP;
    logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, rd;
    logic        REG_WR = 1'b0, REG_RD = 1'b0;
    logic        CMD_READY, RESTORE_VALID, CARRY_OUT, SKIP_FLAG, IRQ_ENABLE;
    logic [3:0]  ACC_OUT, TEMP_OUT, RAM_FILE, RAM_DIGIT, PORT_BIT_SEL;
    logic [9:0]  ROM_DATA;
    logic [7:0]  TABLE_DATA;
    logic [2:0]  STACK_LEVEL;
    int          n_errors = 0, total_checks = 0, cycles = 0;
    pss_row_t    rows [9];

    // rom contents depend on every address bit so a wrong bank or page shows up
    function automatic logic [9:0] rom_word(input logic [13:0] a);
        return a[9:0] ^ {a[13:10], a[13:8]};
    endfunction : rom_word

    assign ROM_DATA = rom_word(ROM_ADDR);

    pss_sequencer dut (
        .CLK(CLK), .RST_N(RST_N), .CE(CE), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ARG(CMD_ARG),
        .CMD_LEN(CMD_LEN), .CMD_READY(CMD_READY), .CARRY_IN(CARRY_IN), .ACC_IN(ACC_IN), .TEMP_IN(TEMP_IN),
        .RESTORE_VALID(RESTORE_VALID), .CARRY_OUT(CARRY_OUT), .ACC_OUT(ACC_OUT), .TEMP_OUT(TEMP_OUT),
        .ROM_ADDR(ROM_ADDR), .ROM_DATA(ROM_DATA), .TABLE_DATA(TABLE_DATA), .IP(IP), .STACK_LEVEL(STACK_LEVEL),
        .SKIP_FLAG(SKIP_FLAG), .IRQ_ENABLE(IRQ_ENABLE), .RAM_GROUP(RAM_GROUP), .RAM_FILE(RAM_FILE),
        .RAM_DIGIT(RAM_DIGIT), .PORT_BIT_SEL(PORT_BIT_SEL), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA)
    );

    always #10 CLK = ~CLK;

    task automatic final_report;
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // holds valid for the taking edge only, then waits for the sequencer to go idle
    task automatic exec(input logic [3:0] op, input logic [13:0] arg, input logic [1:0] len);
        int k;
        @(posedge CLK);
        CMD_VALID <= 1'b1;
        CMD_OP    <= op;
        CMD_ARG   <= arg;
        CMD_LEN   <= len;
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        @(negedge CLK);
        first_addr = ROM_ADDR;
        k = 0;
        while (CMD_READY !== 1'b1 && k < 8) begin
            @(negedge CLK);
            k++;
        end
        chk("cmd_ready", 16'h0001, CMD_READY);
    endtask : exec

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR    <= 1'b0;
        @(negedge CLK);
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a);
        @(posedge CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD   <= 1'b0;
        @(negedge CLK);
        rd = REG_RDATA;
    endtask : reg_rd

    task automatic chk_reset;
        chk("ip", 16'h0000, IP);
        chk("level", 16'h0007, STACK_LEVEL);
        chk("file", 16'h0000, RAM_FILE);
        chk("digit", 16'h0000, RAM_DIGIT);
        chk("skip", 16'h0000, SKIP_FLAG);
        chk("irq_en", 16'h0000, IRQ_ENABLE);
    endtask : chk_reset

    initial begin
        rows = '{
            '{pss_pkg::OP_NEXT,    14'h0000, 2'h1, 14'h0001, 3'h7},
            '{pss_pkg::OP_NEXT,    14'h0000, 2'h2, 14'h0003, 3'h7},
            '{pss_pkg::OP_BRANCH,  14'h007F, 2'h1, 14'h007F, 3'h7},
            '{pss_pkg::OP_NEXT,    14'h0000, 2'h1, 14'h0080, 3'h7},
            '{pss_pkg::OP_CALL_P2, 14'h0005, 2'h1, 14'h0105, 3'h0},
            '{pss_pkg::OP_CALL,    14'h017F, 2'h1, 14'h017F, 3'h1},
            '{pss_pkg::OP_NEXT,    14'h0000, 2'h1, 14'h0180, 3'h1},
            '{pss_pkg::OP_RET,     14'h0000, 2'h1, 14'h0106, 3'h0},
            '{pss_pkg::OP_RET,     14'h0000, 2'h1, 14'h0081, 3'h7}
        };
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        @(negedge CLK);
        chk_reset();
        foreach (rows[i]) begin
            exec(rows[i].op, rows[i].arg, rows[i].len);
            chk("ip", rows[i].ip, IP);
            chk("level", rows[i].lvl, STACK_LEVEL);
        end
        // nine calls: the ninth wraps to level 0 and overwrites entry zero
        for (int i = 0; i < 9; i++) begin
            exec(pss_pkg::OP_CALL, 14'h1000 + 14'(i * 16), 2'h1);
            chk("level", 16'(i % 8), STACK_LEVEL);
        end
        exec(pss_pkg::OP_RET, 14'h0000, 2'h1);
        chk("ip", 16'h1071, IP);
        exec(pss_pkg::OP_CALL, 14'h0300, 2'h1);
        exec(pss_pkg::OP_WAKE, 14'h0000, 2'h1);
        chk("level", 16'h0007, STACK_LEVEL);
        chk("ip", 16'h0300, IP);
        exec(pss_pkg::OP_IRQ_EN, 14'h0001, 2'h1);
        chk("irq_en", 16'h0001, IRQ_ENABLE);
        reg_wr(pss_pkg::REG_DP, 16'h0259);
        chk("ram_ptr", 16'h0259, {RAM_GROUP, RAM_FILE, RAM_DIGIT});
        chk("port_bit", 16'h0009, PORT_BIT_SEL);
        exec(pss_pkg::OP_SKIP_SET, 14'h0000, 2'h1);
        chk("skip", 16'h0001, SKIP_FLAG);
        CARRY_IN <= 1'b1;
        ACC_IN   <= 4'hA;
        TEMP_IN  <= 4'h5;
        exec(pss_pkg::OP_INT, 14'h0004, 2'h1);
        chk("ip", 16'h0084, IP);
        chk("irq_en", 16'h0000, IRQ_ENABLE);
        chk("level", 16'h0000, STACK_LEVEL);
        CARRY_IN <= 1'b0;
        ACC_IN   <= 4'h3;
        TEMP_IN  <= 4'hC;
        reg_wr(pss_pkg::REG_DP, 16'h0000);
        exec(pss_pkg::OP_NEXT, 14'h0000, 2'h1);
        chk("skip", 16'h0000, SKIP_FLAG);
        exec(pss_pkg::OP_UPPER_BANK, 14'h0000, 2'h1);
        exec(pss_pkg::OP_TABLE, 14'h0291, 2'h1);
        chk("tbl_addr", 16'h2291, first_addr);
        chk("tbl_data", 16'(rom_word(14'h2291) & 10'h0FF), TABLE_DATA);
        chk("ip", 16'h0087, IP);
        chk("level", 16'h0000, STACK_LEVEL);
        exec(pss_pkg::OP_LOWER_BANK, 14'h0000, 2'h1);
        exec(pss_pkg::OP_TABLE, 14'h0291, 2'h1);
        chk("tbl_addr", 16'h0291, first_addr);
        reg_rd(pss_pkg::REG_TBL);
        chk("reg_tbl", 16'(rom_word(14'h0291) & 10'h0FF), rd);
        exec(pss_pkg::OP_RETI, 14'h0000, 2'h1);
        chk("restore", 16'h0001, RESTORE_VALID);
        chk("ctx", 16'h01A5, {CARRY_OUT, ACC_OUT, TEMP_OUT});
        chk("ram_ptr", 16'h0259, {RAM_GROUP, RAM_FILE, RAM_DIGIT});
        chk("skip", 16'h0001, SKIP_FLAG);
        chk("ip", 16'h0302, IP);
        chk("level", 16'h0007, STACK_LEVEL);
        reg_rd(pss_pkg::REG_SP);
        chk("reg_sp", 16'h0007, rd);
        reg_rd(4'hF);
        chk("unmapped", 16'h0000, rd);
        reg_wr(pss_pkg::REG_CTRL, 16'h0005);
        chk("skip", 16'h0000, SKIP_FLAG);
        chk("irq_en", 16'h0001, IRQ_ENABLE);
        reg_rd(pss_pkg::REG_CTRL);
        chk("reg_ctrl", 16'h0005, rd);
        reg_rd(pss_pkg::REG_DP);
        chk("reg_dp", 16'h0259, rd);
        reg_rd(pss_pkg::REG_IP);
        chk("reg_ip", 16'h0302, rd);
        reg_rd(pss_pkg::REG_STAT);
        chk("reg_stat", 16'h0000, rd);
        // an unknown code only advances the pointer
        exec(4'hD, 14'h0000, 2'h2);
        chk("ip", 16'h0304, IP);
        // clock enable low: the command edge leaves all state alone
        CE <= 1'b0;
        exec(pss_pkg::OP_NEXT, 14'h0000, 2'h1);
        chk("ce_ip", 16'h0304, IP);
        CE <= 1'b1;
        // second reset in mid-run after the stack has moved
        exec(pss_pkg::OP_CALL, 14'h0400, 2'h1);
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(negedge CLK);
        chk_reset();
        final_report();
    end
endmodule : program_sequencer_stack_tb

// ### rtl/pss_ctx_reg.sv
// one-stage context store, written only by save
module pss_ctx_reg #(
    parameter int W = 20
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         save,
    input  wire logic [W-1:0] save_data,
    output logic      [W-1:0] held
);
    typedef struct packed {
        logic [W-1:0] ctx;
    } pss_ctx_t;

    pss_ctx_t r;
    pss_ctx_t next_r;

    always_comb begin
        next_r = r;
        if (save) begin
            next_r.ctx = save_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign held = r.ctx;
endmodule : pss_ctx_reg

// ### rtl/pss_pkg.sv
package pss_pkg;
    localparam int IP_W      = 14;
    localparam int OFS_W     = 7;
    localparam int PAGE_W    = IP_W - OFS_W;
    localparam int BANKPG_W  = 6;
    localparam int SP_W      = 3;
    localparam int DEPTH     = 8;
    localparam int ROM_W     = 10;
    localparam int TBL_W     = 8;
    localparam int Z_W       = 2;
    localparam int X_W       = 4;
    localparam int Y_W       = 4;
    localparam int ACC_W     = 4;
    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 4;
    localparam int LEN_W     = 2;
    localparam int CTX_W     = Z_W + X_W + Y_W + 2 + 2 * ACC_W;

    localparam logic [SP_W-1:0]   SP_RESET    = 3'h7;
    localparam logic [IP_W-1:0]   IP_RESET    = 14'h0000;
    localparam logic [X_W-1:0]    DP_X_RESET  = 4'h0;
    localparam logic [Y_W-1:0]    DP_Y_RESET  = 4'h0;
    localparam logic [PAGE_W-1:0] VEC_PAGE    = 7'h01;
    localparam logic [PAGE_W-1:0] SUB_PAGE    = 7'h02;

    localparam logic [ADDR_W-1:0] REG_IP      = 4'h0;
    localparam logic [ADDR_W-1:0] REG_SP      = 4'h1;
    localparam logic [ADDR_W-1:0] REG_DP      = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h3;
    localparam logic [ADDR_W-1:0] REG_TBL     = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STAT    = 4'h5;

    localparam int DP_Y_LSB      = 0;
    localparam int DP_X_LSB      = 4;
    localparam int DP_Z_LSB      = 8;
    localparam int CTRL_BANK_BIT = 0;
    localparam int CTRL_SKIP_BIT = 1;
    localparam int CTRL_IRQ_BIT  = 2;
    localparam int STAT_BUSY_BIT = 0;

    typedef enum logic [3:0] {
        OP_NEXT, OP_BRANCH, OP_CALL_P2, OP_CALL, OP_RET, OP_RETI, OP_INT,
        OP_TABLE, OP_SKIP_SET, OP_UPPER_BANK, OP_LOWER_BANK, OP_IRQ_EN, OP_WAKE
    } pss_op_t;
endpackage : pss_pkg

// ### rtl/pss_sequencer.sv
// Contract
// - interrupt entry saves ram pointer, carry, skip, accumulator, temp in context store
// - calls and table reads never write the context store
// - skip flag steers skips and is saved and restored across interrupts
// - stack level pointer is 7 after reset and after backup wake
// - page-two call increments level pointer, then stores return address there
// - call at level 7 wraps to 0 and overwrites entry zero
// - instruction pointer advances by the executed instruction's word count; backup wake leaves it unchanged
// - branch, call, return load the pointer with their target; table read advances it past the read
// - pointer bits top..7 select page, bits 6..0 the word in page
// - passing offset 127 continues at offset 0 of the next page
// - ram pointer is group, file and digit fields
// - digit field also selects the port bit for port-bit ops
// - group field is not initialised by reset
// - program words are 10 bits, pages of 128 words
// - table reads use pages 64..127 after upper bank, 0..63 after lower
// - interrupt loads its vector in page 1 into the pointer
// - one-word page-two call reaches page 2 from any page
// - page-two call target may run on past page 2
// - table read returns bits 7..0 of the ROM word
// - eight stack entries, 3-bit pointer, shared by calls, interrupts, tables
// - interrupt entry pushes return address, loads vector, clears irq enable
module pss_sequencer (
    input  wire logic                           CLK,
    input  wire logic                           RST_N,
    input  wire logic                           CE,
    input  wire logic                           CMD_VALID,
    input  wire logic [3:0]                     CMD_OP,
    input  wire logic [pss_pkg::IP_W-1:0]       CMD_ARG,
    input  wire logic [pss_pkg::LEN_W-1:0]      CMD_LEN,
    output logic                                CMD_READY,
    input  wire logic                           CARRY_IN,
    input  wire logic [pss_pkg::ACC_W-1:0]      ACC_IN,
    input  wire logic [pss_pkg::ACC_W-1:0]      TEMP_IN,
    output logic                                RESTORE_VALID,
    output logic                                CARRY_OUT,
    output logic [pss_pkg::ACC_W-1:0]           ACC_OUT,
    output logic [pss_pkg::ACC_W-1:0]           TEMP_OUT,
    output logic [pss_pkg::IP_W-1:0]            ROM_ADDR,
    input  wire logic [pss_pkg::ROM_W-1:0]      ROM_DATA,
    output logic [pss_pkg::TBL_W-1:0]           TABLE_DATA,
    output logic [pss_pkg::IP_W-1:0]            IP,
    output logic [pss_pkg::SP_W-1:0]            STACK_LEVEL,
    output logic                                SKIP_FLAG,
    output logic                                IRQ_ENABLE,
    output logic [pss_pkg::Z_W-1:0]             RAM_GROUP,
    output logic [pss_pkg::X_W-1:0]             RAM_FILE,
    output logic [pss_pkg::Y_W-1:0]             RAM_DIGIT,
    output logic [pss_pkg::Y_W-1:0]             PORT_BIT_SEL,
    input  wire logic [pss_pkg::ADDR_W-1:0]     REG_ADDR,
    input  wire logic [pss_pkg::DATA_W-1:0]     REG_WDATA,
    input  wire logic                           REG_WR,
    input  wire logic                           REG_RD,
    output logic [pss_pkg::DATA_W-1:0]          REG_RDATA
);
    typedef enum logic [1:0] {ST_IDLE, ST_TBL, ST_POP} pss_state_t;

    typedef struct packed {
        pss_state_t                     st;
        logic [pss_pkg::IP_W-1:0]       ip;
        logic [pss_pkg::IP_W-1:0]       rom_addr;
        logic [pss_pkg::SP_W-1:0]       sp;
        logic [pss_pkg::Z_W-1:0]        dp_z;
        logic [pss_pkg::X_W-1:0]        dp_x;
        logic [pss_pkg::Y_W-1:0]        dp_y;
        logic                           bank_hi;
        logic                           skip;
        logic                           irq_en;
        logic                           from_int;
        logic [pss_pkg::TBL_W-1:0]      tbl;
        logic                           rst_valid;
        logic                           carry;
        logic [pss_pkg::ACC_W-1:0]      acc;
        logic [pss_pkg::ACC_W-1:0]      temp;
        logic [pss_pkg::DATA_W-1:0]     rdata;
    } pss_seq_t;

    pss_seq_t                     r;
    pss_seq_t                     next_r;
    pss_seq_t                     rst_r;
    logic                         push;
    logic [pss_pkg::IP_W-1:0]     push_data;
    logic                         ctx_save;
    logic [pss_pkg::CTX_W-1:0]    ctx_in;
    logic [pss_pkg::CTX_W-1:0]    ctx_held;
    logic [pss_pkg::IP_W-1:0]     stk_rd;
    logic [pss_pkg::IP_W-1:0]     ip_seq;
    logic                         take;
    pss_pkg::pss_op_t             op;

    assign op     = pss_pkg::pss_op_t'(CMD_OP);
    assign take   = CMD_VALID && (r.st == ST_IDLE);
    // binary add carries from the offset into the page field
    assign ip_seq = r.ip + pss_pkg::IP_W'(CMD_LEN);
    // context layout: group, file, digit, carry, skip, acc, temp
    assign ctx_in = {r.dp_z, r.dp_x, r.dp_y, CARRY_IN, r.skip, ACC_IN, TEMP_IN};

    pss_stack_mem #(
        .W     (pss_pkg::IP_W),
        .DEPTH (pss_pkg::DEPTH),
        .AW    (pss_pkg::SP_W)
    ) u_stack (
        .clk     (CLK),
        .rst_n   (RST_N),
        .ce      (CE),
        .wr_en   (push),
        .wr_addr (next_r.sp),
        .wr_data (push_data),
        .rd_addr (r.sp),
        .rd_data (stk_rd)
    );

    pss_ctx_reg #(
        .W (pss_pkg::CTX_W)
    ) u_ctx (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .save      (ctx_save),
        .save_data (ctx_in),
        .held      (ctx_held)
    );

    always_comb begin
        rst_r          = '0;
        rst_r.st       = ST_IDLE;
        rst_r.ip       = pss_pkg::IP_RESET;
        rst_r.rom_addr = pss_pkg::IP_RESET;
        rst_r.sp       = pss_pkg::SP_RESET;
        rst_r.dp_x     = pss_pkg::DP_X_RESET;
        rst_r.dp_y     = pss_pkg::DP_Y_RESET;
        rst_r.dp_z     = r.dp_z;
    end

    always_comb begin
        next_r           = r;
        next_r.rst_valid = 1'b0;
        next_r.rdata     = '0;
        push             = 1'b0;
        push_data        = ip_seq;
        ctx_save         = 1'b0;
        case (r.st)
            ST_IDLE: begin
                if (take) begin
                    case (op)
                        pss_pkg::OP_NEXT: begin
                            next_r.ip   = ip_seq;
                            next_r.skip = 1'b0;
                        end
                        pss_pkg::OP_BRANCH: begin
                            next_r.ip = CMD_ARG;
                        end
                        pss_pkg::OP_CALL_P2, pss_pkg::OP_CALL: begin
                            // level wraps 7 -> 0, no overflow guard
                            next_r.sp = r.sp + 1'b1;
                            push      = 1'b1;
                            if (op == pss_pkg::OP_CALL_P2) begin
                                next_r.ip = {pss_pkg::SUB_PAGE, CMD_ARG[pss_pkg::OFS_W-1:0]};
                            end else begin
                                next_r.ip = CMD_ARG;
                            end
                        end
                        pss_pkg::OP_RET, pss_pkg::OP_RETI: begin
                            next_r.st       = ST_POP;
                            next_r.from_int = (op == pss_pkg::OP_RETI);
                        end
                        pss_pkg::OP_INT: begin
                            // the interrupted instruction is re-run on return
                            next_r.sp     = r.sp + 1'b1;
                            push          = 1'b1;
                            push_data     = r.ip;
                            ctx_save      = 1'b1;
                            next_r.ip     = {pss_pkg::VEC_PAGE, CMD_ARG[pss_pkg::OFS_W-1:0]};
                            next_r.irq_en = 1'b0;
                        end
                        pss_pkg::OP_TABLE: begin
                            next_r.sp       = r.sp + 1'b1;
                            push            = 1'b1;
                            next_r.st       = ST_TBL;
                            next_r.from_int = 1'b0;
                        end
                        pss_pkg::OP_SKIP_SET: begin
                            next_r.skip = 1'b1;
                            next_r.ip   = ip_seq;
                        end
                        pss_pkg::OP_UPPER_BANK: begin
                            next_r.bank_hi = 1'b1;
                            next_r.ip      = ip_seq;
                        end
                        pss_pkg::OP_LOWER_BANK: begin
                            next_r.bank_hi = 1'b0;
                            next_r.ip      = ip_seq;
                        end
                        pss_pkg::OP_IRQ_EN: begin
                            next_r.irq_en = CMD_ARG[0];
                            next_r.ip     = ip_seq;
                        end
                        pss_pkg::OP_WAKE: begin
                            next_r.sp = pss_pkg::SP_RESET;
                        end
                        default: begin
                            next_r.ip = ip_seq;
                        end
                    endcase
                end
            end
            ST_TBL: begin
                next_r.tbl = ROM_DATA[pss_pkg::TBL_W-1:0];
                next_r.st  = ST_POP;
            end
            ST_POP: begin
                next_r.ip = stk_rd;
                next_r.sp = r.sp - 1'b1;
                next_r.st = ST_IDLE;
                if (r.from_int) begin
                    {next_r.dp_z, next_r.dp_x, next_r.dp_y, next_r.carry, next_r.skip,
                     next_r.acc, next_r.temp} = ctx_held;
                    next_r.rst_valid = 1'b1;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
        // the table address holds only while the word is fetched
        if (next_r.st == ST_TBL) begin
            next_r.rom_addr = {r.bank_hi, CMD_ARG[pss_pkg::OFS_W+pss_pkg::BANKPG_W-1:pss_pkg::OFS_W],
                               CMD_ARG[pss_pkg::OFS_W-1:0]};
        end else begin
            next_r.rom_addr = next_r.ip;
        end
        // bus writes land after the sequencer update, so software wins a same-cycle clash, except a skip newly raised by the sequencer
        if (REG_WR) begin
            case (REG_ADDR)
                pss_pkg::REG_DP: begin
                    next_r.dp_y = REG_WDATA[pss_pkg::DP_Y_LSB +: pss_pkg::Y_W];
                    next_r.dp_x = REG_WDATA[pss_pkg::DP_X_LSB +: pss_pkg::X_W];
                    next_r.dp_z = REG_WDATA[pss_pkg::DP_Z_LSB +: pss_pkg::Z_W];
                end
                pss_pkg::REG_CTRL: begin
                    next_r.bank_hi = REG_WDATA[pss_pkg::CTRL_BANK_BIT];
                    next_r.irq_en  = REG_WDATA[pss_pkg::CTRL_IRQ_BIT];
                    // a skip raised by the sequencer this cycle is kept
                    next_r.skip    = REG_WDATA[pss_pkg::CTRL_SKIP_BIT] | (next_r.skip & ~r.skip);
                end
                default: begin
                end
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                pss_pkg::REG_IP:   next_r.rdata = pss_pkg::DATA_W'(r.ip);
                pss_pkg::REG_SP:   next_r.rdata = pss_pkg::DATA_W'(r.sp);
                pss_pkg::REG_DP:   next_r.rdata = pss_pkg::DATA_W'({r.dp_z, r.dp_x, r.dp_y});
                pss_pkg::REG_CTRL: next_r.rdata = pss_pkg::DATA_W'({r.irq_en, r.skip, r.bank_hi});
                pss_pkg::REG_TBL:  next_r.rdata = pss_pkg::DATA_W'(r.tbl);
                pss_pkg::REG_STAT: next_r.rdata = pss_pkg::DATA_W'(r.st != ST_IDLE);
                default:           next_r.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            r <= rst_r;
        end else if (CE) begin
            r <= next_r;
        end
    end

    assign CMD_READY     = (r.st == ST_IDLE);
    assign RESTORE_VALID = r.rst_valid;
    assign CARRY_OUT     = r.carry;
    assign ACC_OUT       = r.acc;
    assign TEMP_OUT      = r.temp;
    assign ROM_ADDR      = r.rom_addr;
    assign TABLE_DATA    = r.tbl;
    assign IP            = r.ip;
    assign STACK_LEVEL   = r.sp;
    assign SKIP_FLAG     = r.skip;
    assign IRQ_ENABLE    = r.irq_en;
    assign RAM_GROUP     = r.dp_z;
    assign RAM_FILE      = r.dp_x;
    assign RAM_DIGIT     = r.dp_y;
    assign PORT_BIT_SEL  = r.dp_y;
    assign REG_RDATA     = r.rdata;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_sp_reset;
        $rose(RST_N) |-> STACK_LEVEL == 3'h7;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("level not 7 after reset");

    property p_call_push;
        CE && take && op == pss_pkg::OP_CALL_P2 |=> STACK_LEVEL == $past(STACK_LEVEL) + 3'h1
            && IP == {7'h02, $past(CMD_ARG[6:0])};
    endproperty
    a_call_push: assert property (p_call_push) else $error("page-two call wrong");

    property p_wrap;
        CE && take && op == pss_pkg::OP_CALL && STACK_LEVEL == 3'h7 |=> STACK_LEVEL == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("level did not wrap");

    property p_advance;
        CE && take && op == pss_pkg::OP_NEXT && !REG_WR |=> IP == $past(IP) + 14'($past(CMD_LEN));
    endproperty
    a_advance: assert property (p_advance) else $error("pointer advance wrong");

    property p_vector;
        CE && take && op == pss_pkg::OP_INT && !REG_WR |=> IP[13:7] == 7'h01 && !IRQ_ENABLE;
    endproperty
    a_vector: assert property (p_vector) else $error("vector entry wrong");

    property p_ret;
        CE && take && op == pss_pkg::OP_RET ##1 CE |=> STACK_LEVEL == $past(STACK_LEVEL, 2) - 3'h1;
    endproperty
    a_ret: assert property (p_ret) else $error("return level wrong");

    property p_ctx_only_int;
        !(CE && take && op == pss_pkg::OP_INT) |=> $stable(ctx_held);
    endproperty
    a_ctx_only_int: assert property (p_ctx_only_int) else $error("context written by non-interrupt");

    property p_table;
        CE && r.st == ST_TBL |=> TABLE_DATA == $past(ROM_DATA[7:0]) && r.st == ST_POP;
    endproperty
    a_table: assert property (p_table) else $error("table data wrong");

    property p_tbl_bank;
        r.st == ST_TBL |-> ROM_ADDR[13] == r.bank_hi;
    endproperty
    a_tbl_bank: assert property (p_tbl_bank) else $error("table bank wrong");

    property p_port_sel;
        CE && REG_WR && REG_ADDR == pss_pkg::REG_DP |=> PORT_BIT_SEL == $past(REG_WDATA[3:0]);
    endproperty
    a_port_sel: assert property (p_port_sel) else $error("port bit select mismatch");

    c_int_reti: cover property (take && op == pss_pkg::OP_INT ##[1:20] RESTORE_VALID);
    c_wrap: cover property (take && op == pss_pkg::OP_CALL_P2 && STACK_LEVEL == 3'h7);
    c_table: cover property (take && op == pss_pkg::OP_TABLE ##3 CMD_READY);
    c_page_cross: cover property (take && op == pss_pkg::OP_NEXT && IP[6:0] == 7'h7F);
endmodule : pss_sequencer

// ### rtl/pss_stack_mem.sv
// eight-entry return-address store; read data registered
module pss_stack_mem #(
    parameter int W     = 14,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } pss_stk_t;

    pss_stk_t r;
    pss_stk_t next_r;

    always_comb begin
        next_r    = r;
        next_r.rd = r.mem[rd_addr];
        if (wr_en) begin
            next_r.mem[wr_addr] = wr_data;
        end
    end

    // entries are data: reset clears only the read register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r.rd <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign rd_data = r.rd;
endmodule : pss_stack_mem
